// [evp_pkg.sv]
package evp_pkg;

  // ------------------------------------------------------------------
  // bus and register map (printed offsets are register indices)
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam logic [5:0]  IDX_TEST_CTRL  = 6'h15;
  localparam logic [5:0]  IDX_TEST_DATA  = 6'h16;
  localparam logic [5:0]  IDX_PROMO      = 6'h1f;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  // ------------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------------
  localparam int unsigned WE_BIT         = 4;
  localparam int unsigned SEL_W          = 4;
  localparam logic [7:0]  PROMO_RESET    = 8'hf2;
  localparam logic [7:0]  PROMO_MAX      = 8'hf2;
  localparam logic [3:0]  SEL_TOP        = 4'hf;
  localparam logic [7:0]  TOP_GROUP_MASK = 8'h07;
  localparam logic [3:0]  SEL_RESET      = 4'h0;

  // ------------------------------------------------------------------
  // request slots: slot n answers vector 0xff00 + 2n
  // ------------------------------------------------------------------
  localparam int unsigned NUM_SLOT       = 128;
  localparam int unsigned NUM_PERIPH     = 121;
  localparam logic [6:0]  IRQ_IDX        = 7'h79;
  localparam logic [6:0]  X_IDX          = 7'h7a;
  localparam int unsigned NUM_SRC        = 123;

  // ------------------------------------------------------------------
  // vector bytes
  // ------------------------------------------------------------------
  localparam logic [7:0]  VEC_HIGH       = 8'hff;
  localparam logic [7:0]  VEC_POR        = 8'hfe;
  localparam logic [7:0]  VEC_CMR        = 8'hfc;
  localparam logic [7:0]  VEC_WDOG       = 8'hfa;
  localparam logic [7:0]  VEC_TRAP       = 8'hf8;
  localparam logic [7:0]  VEC_SWI        = 8'hf6;
  localparam logic [7:0]  VEC_X          = 8'hf4;

  // non-maskable and reset exception requests from the core
  typedef struct packed {
    logic power_on_reset;
    logic clock_monitor_reset;
    logic watchdog_reset;
    logic unimplemented_opcode;
    logic software_exception;
    logic background_debug_controller;
  } evp_exc_s;

  // mask bits of the processor condition flags
  typedef struct packed {
    logic i_mask;
    logic x_mask;
  } evp_flags_s;

endpackage : evp_pkg

// [evp_vector_unit.sv]
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - up to 122 I-maskable sources, vectors 0xff00 to 0xfff2
// - one X-maskable source at vector 0xfff4
// - software exception and debug request share non-maskable vector 0xfff6
// - unimplemented opcode trap uses non-maskable vector 0xfff8
// - three reset vectors 0xfffa to 0xfffe: pin/power-on, clock monitor, watchdog
// - winning vector is driven on the address bus during vector fetch
// - pending flag raised while any enabled interrupt awaits service
// - blocking inputs suppress I-class and X-class service requests
// - wake-up on qualifying interrupt, or on x-class pin even when masked
// - clockless request path covering all I and X sources
// - software selection promotes one I source to top I priority
// - same in normal and emulation modes; test facilities only in special modes
// - maskable and x-class pin levels come from external bus interface
// - registers at indices 0x15, 0x16, 0x1f from module base
// - test write enable bit 4: read anytime, write special with I and X masked
// - enable low: test data writes ignored, reads show live inputs
// - enable high: test data drives decoder instead of real inputs
// - requests pending when enable sets stay until overwritten
// - select field bits 3:0, read/write anytime, picks eight vectors
// - test data reads zero in normal modes
// - select 0xf exposes only bits 2:0, upper bits read zero
// - unimplemented test register: writes dropped, reads zero
// - promotion value above 0xf2 promotes the maskable pin source 0xfff2
module evp_vector_unit (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  // axi4-lite slave
  input  wire logic [evp_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [evp_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // interrupt sources
  input  wire logic [evp_pkg::NUM_PERIPH-1:0] periph_req,
  input  wire logic                          irq_pin_n,
  input  wire logic                          x_class_interrupt_pin_n,
  input  wire evp_pkg::evp_exc_s             exc_req,
  // core status
  input  wire evp_pkg::evp_flags_s           processor_condition_flags,
  input  wire logic                          special_mode,
  input  wire logic                          block_i,
  input  wire logic                          block_x,
  input  wire logic                          vector_fetch,
  // toward the processor
  output logic                               int_pending,
  output logic [15:0]                        vector_addr,
  output logic                               vector_drive,
  output logic                               wakeup,
  output logic                               async_wakeup
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // register index from a byte address; low two bits must be zero
  function automatic logic [6:0] reg_index(input logic [evp_pkg::ADDR_W-1:0] addr);
    reg_index = {addr[1:0] != 2'b00, addr[evp_pkg::ADDR_W-1:2]};
  endfunction : reg_index

  // eight-bit window of a slot vector picked by the select field
  function automatic logic [7:0] group_of(input logic [evp_pkg::NUM_SLOT-1:0] v,
                                          input logic [3:0]                   sel);
    logic [7:0] g;
    g = v[{sel, 3'b000} +: 8];
    if (sel == evp_pkg::SEL_TOP)
      g = g & evp_pkg::TOP_GROUP_MASK;
    group_of = g;
  endfunction : group_of

  // highest set slot among the I-maskable sources
  function automatic logic [6:0] top_index(input logic [evp_pkg::NUM_SLOT-1:0] v);
    logic [6:0] idx;
    idx = 7'h00;
    for (int i = 0; i < int'(evp_pkg::X_IDX); i++)
    begin
      if (v[i])
        idx = 7'(i);
    end
    top_index = idx;
  endfunction : top_index

  // ------------------------------------------------------------------
  // registers and request vectors
  // ------------------------------------------------------------------
  logic                          test_write_enable;
  logic [3:0]                    test_select;
  logic [7:0]                    priority_promotion_select;
  logic [evp_pkg::NUM_SLOT-1:0]  test_force;
  logic [evp_pkg::NUM_SLOT-1:0]  live_req;
  logic [evp_pkg::NUM_SLOT-1:0]  dec_req;
  logic [evp_pkg::NUM_SLOT-1:0]  i_only;
  logic [6:0]                    promo_idx;
  logic                          en_i;
  logic                          en_x;
  logic                          any_i;
  logic                          any_x;
  logic                          have_exc;
  logic [7:0]                    next_vec_low;

  logic                          aw_got;
  logic                          w_got;
  logic [evp_pkg::ADDR_W-1:0]    aw_addr;
  logic [31:0]                   w_data;
  logic [3:0]                    w_strb;
  logic                          do_write;
  logic                          wr_low;
  logic [6:0]                    wr_idx;
  logic                          wr_hit;
  logic [6:0]                    rd_idx;
  logic [31:0]                   next_rdata;
  logic                          rd_hit;

  // pins arrive active low from the external bus interface
  assign live_req = {{(evp_pkg::NUM_SLOT - evp_pkg::NUM_SRC){1'b0}},
                     ~x_class_interrupt_pin_n, ~irq_pin_n, periph_req};

  // test data replaces the real inputs
  assign dec_req = test_write_enable ? test_force : live_req;

  // blocking inputs gate both maskable classes
  assign en_i = !processor_condition_flags.i_mask && !block_i;
  assign en_x = !processor_condition_flags.x_mask && !block_x;

  // only slots below the x-class slot are I-maskable
  assign i_only = dec_req & {{(evp_pkg::NUM_SLOT - 32'(evp_pkg::X_IDX)){1'b0}},
                             {32'(evp_pkg::X_IDX){1'b1}}};
  assign any_i  = |i_only;
  assign any_x  = dec_req[evp_pkg::X_IDX];

  // out-of-range promotion falls back to the pin source
  assign promo_idx = (priority_promotion_select > evp_pkg::PROMO_MAX) ?
                     evp_pkg::IRQ_IDX : priority_promotion_select[7:1];

  // ------------------------------------------------------------------
  // priority resolution
  // ------------------------------------------------------------------

  // fixed order, resets first, then descending vectors
  always_comb
  begin
    have_exc     = 1'b1;
    next_vec_low = evp_pkg::VEC_POR;
    if (exc_req.power_on_reset)
      next_vec_low = evp_pkg::VEC_POR;
    else if (exc_req.clock_monitor_reset)
      next_vec_low = evp_pkg::VEC_CMR;
    else if (exc_req.watchdog_reset)
      next_vec_low = evp_pkg::VEC_WDOG;
    else if (exc_req.unimplemented_opcode)
      next_vec_low = evp_pkg::VEC_TRAP;
    else if (exc_req.software_exception || exc_req.background_debug_controller)
      next_vec_low = evp_pkg::VEC_SWI;
    else if (any_x && en_x)
      next_vec_low = evp_pkg::VEC_X;
    // promoted source beats other I sources
    else if (any_i && en_i && i_only[promo_idx])
      next_vec_low = {promo_idx, 1'b0};
    else if (any_i && en_i)
      next_vec_low = {top_index(i_only), 1'b0};
    else
      have_exc = 1'b0;
  end

  // vector captured every cycle, marked valid during the fetch
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      vector_addr  <= {evp_pkg::VEC_HIGH, evp_pkg::VEC_POR};
      vector_drive <= 1'b0;
    end
    else
    begin
      vector_addr  <= {evp_pkg::VEC_HIGH, next_vec_low};
      vector_drive <= vector_fetch && have_exc;
    end
  end

  // pending and wake-up flags toward the core
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      int_pending <= 1'b0;
      wakeup      <= 1'b0;
    end
    else
    begin
      int_pending <= (any_i && en_i) || (any_x && en_x);
      // x-class pin wakes even when masked
      wakeup      <= (any_i && en_i) || (any_x && en_x) || !x_class_interrupt_pin_n;
    end
  end

  // clocks may be stopped, so this path cannot pass through a flip-flop
  // clockless wake request
  assign async_wakeup = (|live_req) || (|test_force);

  // ------------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------------
  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign wr_idx   = reg_index(aw_addr);
  assign wr_low   = do_write && w_strb[0];
  assign wr_hit   = (wr_idx == {1'b0, evp_pkg::IDX_TEST_CTRL}) ||
                    (wr_idx == {1'b0, evp_pkg::IDX_TEST_DATA}) ||
                    (wr_idx == {1'b0, evp_pkg::IDX_PROMO});

  // address and data taken in either order, response after both
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= evp_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got        <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? evp_pkg::RESP_OKAY : evp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_got        <= 1'b0;
        w_got         <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------

  // test control: select anytime, enable guarded
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      test_write_enable <= 1'b0;
      test_select       <= evp_pkg::SEL_RESET;
    end
    else if (wr_low && wr_idx == {1'b0, evp_pkg::IDX_TEST_CTRL})
    begin
      test_select <= w_data[evp_pkg::SEL_W-1:0];
      // enable needs special mode with both masks set
      // test facilities only in special modes
      if (special_mode && processor_condition_flags.i_mask &&
          processor_condition_flags.x_mask)
        test_write_enable <= w_data[evp_pkg::WE_BIT];
    end
  end

  // a write is refused silently, so software sees the old value on read
  // promotion select, written only with I mask set
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      priority_promotion_select <= evp_pkg::PROMO_RESET;
    else if (wr_low && wr_idx == {1'b0, evp_pkg::IDX_PROMO} &&
             processor_condition_flags.i_mask)
      priority_promotion_select <= w_data[7:0];
  end

  // forced requests follow live inputs until the enable is set
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      test_force <= '0;
    // pending requests carried into test mode
    else if (!test_write_enable)
      test_force <= live_req;
    // writes only while the enable is high
    // slots above the x-class slot are not implemented
    else if (wr_low && wr_idx == {1'b0, evp_pkg::IDX_TEST_DATA} && special_mode &&
             processor_condition_flags.i_mask)
    begin
      for (int b = 0; b < 8; b++)
      begin
        if (32'({test_select, 3'b000}) + 32'(b) < evp_pkg::NUM_SRC)
          test_force[{test_select, 3'b000} + 7'(b)] <= w_data[b];
      end
    end
  end

  // ------------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------------
  assign rd_idx = reg_index(s_axi_araddr);

  // read mux with zero above the byte
  always_comb
  begin
    next_rdata = '0;
    rd_hit     = 1'b1;
    case (rd_idx)
      {1'b0, evp_pkg::IDX_TEST_CTRL}:
      begin
        next_rdata[evp_pkg::WE_BIT]     = test_write_enable;
        next_rdata[evp_pkg::SEL_W-1:0]  = test_select;
      end
      {1'b0, evp_pkg::IDX_TEST_DATA}:
      begin
        // live inputs shown while enable is low
        if (special_mode)
          next_rdata[7:0] = group_of(test_write_enable ? test_force : live_req,
                                     test_select);
      end
      {1'b0, evp_pkg::IDX_PROMO}:
        next_rdata[7:0] = priority_promotion_select;
      default:
        rd_hit = 1'b0;
    endcase
  end

  // one read in flight; data registered at the address handshake
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= evp_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= rd_hit ? evp_pkg::RESP_OKAY : evp_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : evp_vector_unit

// [evp_core_model.sv]
`timescale 1ns/100ps
// ------------------------------------------------------------------
// processor side: raises the fetch strobe and latches the vector
// ------------------------------------------------------------------
module evp_core_model (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        fetch_go,
  input  wire logic        vector_drive,
  input  wire logic [15:0] vector_addr,
  output logic             vector_fetch,
  output logic [15:0]      fetched
);
  // fetch strobe follows the bench request one cycle late
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      vector_fetch <= 1'b0;
    else
      vector_fetch <= fetch_go;

  // the bus only counts while the unit drives it, so idle cycles leave the latch alone
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      fetched <= 16'h5a5a;
    else if (vector_drive)
      fetched <= vector_addr;
endmodule : evp_core_model

// [evp_vector_unit_checker.sv]
`timescale 1ns/100ps
module evp_vector_unit_checker (
  input wire logic                            mclk,
  input wire logic                            resetn,
  input wire logic                            s_axi_arvalid,
  input wire logic                            s_axi_arready,
  input wire logic                            s_axi_rvalid,
  input wire logic [evp_pkg::NUM_PERIPH-1:0]  periph_req,
  input wire logic                            irq_pin_n,
  input wire logic                            x_class_interrupt_pin_n,
  input wire evp_pkg::evp_exc_s               exc_req,
  input wire evp_pkg::evp_flags_s             processor_condition_flags,
  input wire logic                            special_mode,
  input wire logic                            block_i,
  input wire logic                            block_x,
  input wire logic                            vector_fetch,
  input wire logic                            int_pending,
  input wire logic [15:0]                     vector_addr,
  input wire logic                            vector_drive,
  input wire logic                            wakeup,
  input wire logic                            async_wakeup
);
  // ------------------------------------------------------------------
  // enabled request terms; test forcing can only be switched on or off in special mode, and stays on after special mode ends
  // ------------------------------------------------------------------
  logic x_live;
  logic i_live;
  assign x_live = !x_class_interrupt_pin_n && !processor_condition_flags.x_mask && !block_x;
  assign i_live = (!irq_pin_n || (periph_req != '0)) && !processor_condition_flags.i_mask
                  && !block_i;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_answer;
    s_axi_rvalid && !s_axi_arready;
  endsequence
  sequence s_fetch_exc;
    vector_fetch && (exc_req != '0);
  endsequence

  a_por_vector: assert property (
    exc_req.power_on_reset |=> vector_addr == 16'hfffe) else $error("power-on vector wrong");
  a_cmr_vector: assert property (
    exc_req[5:4] == 2'b01 |=> vector_addr == 16'hfffc) else $error("clock monitor vector wrong");
  a_wdog_vector: assert property (
    exc_req[5:3] == 3'b001 |=> vector_addr == 16'hfffa) else $error("watchdog vector wrong");
  a_trap_vector: assert property (
    exc_req[5:2] == 4'b0001 |=> vector_addr == 16'hfff8) else $error("trap vector wrong");
  a_swi_vector: assert property (
    exc_req[5:2] == 4'b0 && exc_req[1:0] != 2'b0 |=> vector_addr == 16'hfff6)
    else $error("software vector wrong");
  a_x_vector: assert property (disable iff (!resetn || special_mode)
    exc_req == '0 && x_live |=> vector_addr == 16'hfff4) else $error("x vector wrong");
  a_pend_set: assert property (disable iff (!resetn || special_mode)
    x_live || i_live |=> int_pending) else $error("pending missing");
  a_pend_clear: assert property (disable iff (!resetn || special_mode)
    !(x_live || i_live) |=> !int_pending) else $error("pending while blocked");
  a_wake_xpin: assert property (
    !x_class_interrupt_pin_n |=> wakeup) else $error("no wake on x pin");
  a_async_path: assert property (
    !x_class_interrupt_pin_n || !irq_pin_n |-> async_wakeup) else $error("no async wake");
  a_fetch_drive: assert property (
    s_fetch_exc |=> vector_drive) else $error("vector not driven");
  a_read_answer: assert property (
    s_ar_taken |=> s_r_answer) else $error("read not answered");
endmodule : evp_vector_unit_checker

bind evp_vector_unit evp_vector_unit_checker chk (.mclk, .resetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .periph_req, .irq_pin_n, .x_class_interrupt_pin_n, .exc_req,
  .processor_condition_flags, .special_mode, .block_i, .block_x, .vector_fetch, .int_pending,
  .vector_addr, .vector_drive, .wakeup, .async_wakeup);

// [evp_vector_unit_tb.sv]
`timescale 1ns/100ps
module evp_vector_unit_tb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        mclk, resetn, irq_pin_n, x_pin_n, special_mode, block_i, block_x;
  logic        vector_fetch, fetch_go, int_pending, vector_drive, wakeup, async_wakeup;
  logic [120:0] periph_req;
  logic [15:0] vector_addr, fetched;
  evp_pkg::evp_exc_s   exc_req;
  evp_pkg::evp_flags_s flags;
  int          mismatches, checked, cycles;
  logic [15:0] vt [6] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff6};
  localparam logic [1:0] OK = evp_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = evp_pkg::RESP_SLVERR;

  evp_vector_unit dut (.mclk, .resetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .periph_req, .irq_pin_n, .x_class_interrupt_pin_n(x_pin_n), .exc_req,
    .processor_condition_flags(flags), .special_mode, .block_i, .block_x, .vector_fetch,
    .int_pending, .vector_addr, .vector_drive, .wakeup, .async_wakeup);
  evp_core_model core (.mclk, .resetn, .fetch_go, .vector_drive, .vector_addr,
    .vector_fetch, .fetched);

  // ------------------------------------------------------------------
  // clock, hang guard and shared tasks
  // ------------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // a stuck handshake would otherwise hang the run silently
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp_val("bresp", {14'h0, er}, {14'h0, s_axi_bresp});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [15:0] exp, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp_val("rdata", exp, s_axi_rdata[15:0]);
    cmp_val("rresp", {14'h0, er}, {14'h0, s_axi_rresp});
  endtask : axi_rd

  // registered vector lands one edge after the inputs; the fetch adds three more
  task automatic vec(input logic [15:0] exp, input bit chk_f);
    @(posedge mclk);
    fetch_go <= 1'b1;
    @(posedge mclk);
    fetch_go <= 1'b0;
    repeat (3) @(posedge mclk);
    cmp_val("vector", exp, vector_addr);
    if (chk_f) cmp_val("fetched", exp, fetched);
  endtask : vec

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, fetch_go, special_mode} = '0;
    {block_i, block_x, periph_req, exc_req, mismatches, checked} = '0;
    {resetn, irq_pin_n, x_pin_n, flags} = 5'b01111;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    axi_rd(8'h54, 16'h0000, OK);
    axi_rd(8'h7c, 16'h00f2, OK);
    axi_rd(8'h58, 16'h0000, OK);
    axi_rd(8'h60, 16'h0000, ERR);
    axi_wr(8'h55, 8'h01, ERR);
    for (int i = 0; i < 6; i++)
    begin
      exc_req <= 6'h20 >> i;
      vec(vt[i], 1'b1);
    end
    exc_req <= 6'h3f;
    vec(16'hfffe, 1'b1);
    exc_req <= 6'h00;
    flags <= 2'b00;
    x_pin_n <= 1'b0;
    periph_req <= 121'h20;
    vec(16'hfff4, 1'b1);
    cmp_val("pending", 16'h1, {15'h0, int_pending});
    x_pin_n <= 1'b1;
    periph_req <= 121'h420;
    vec(16'hff14, 1'b1);
    irq_pin_n <= 1'b0;
    vec(16'hfff2, 1'b1);
    block_i <= 1'b1;
    block_x <= 1'b1;
    x_pin_n <= 1'b0;
    vec(16'hfffe, 1'b0);
    cmp_val("pending", 16'h0, {15'h0, int_pending});
    cmp_val("wakeup", 16'h1, {15'h0, wakeup});
    {block_i, block_x} <= 2'b00;
    x_pin_n <= 1'b1;
    irq_pin_n <= 1'b1;
    flags <= 2'b10;
    axi_wr(8'h7c, 8'h0a, OK);
    flags <= 2'b00;
    axi_wr(8'h7c, 8'h04, OK);
    axi_rd(8'h7c, 16'h000a, OK);
    vec(16'hff0a, 1'b1);
    flags <= 2'b11;
    periph_req <= 121'h1 << 97;
    axi_wr(8'h54, 8'h1c, OK);
    axi_rd(8'h54, 16'h000c, OK);
    special_mode <= 1'b1;
    axi_rd(8'h58, 16'h0002, OK);
    axi_wr(8'h58, 8'h40, OK);
    axi_rd(8'h58, 16'h0002, OK);
    axi_wr(8'h54, 8'h1c, OK);
    axi_rd(8'h54, 16'h001c, OK);
    periph_req <= '0;
    axi_rd(8'h58, 16'h0002, OK);
    axi_wr(8'h58, 8'h80, OK);
    axi_rd(8'h58, 16'h0080, OK);
    flags <= 2'b00;
    vec(16'hffce, 1'b0);
    flags <= 2'b11;
    axi_wr(8'h54, 8'h1f, OK);
    axi_wr(8'h58, 8'hff, OK);
    axi_rd(8'h58, 16'h0007, OK);
    // second reset clears the test state before normal mode returns
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    special_mode <= 1'b0;
    resetn <= 1'b1;
    axi_rd(8'h54, 16'h0000, OK);
    test_done();
  end
endmodule : evp_vector_unit_tb
